// ---- design/branch_skip_map.vh ----
`ifndef BRANCH_SKIP_MAP_VH
`define BRANCH_SKIP_MAP_VH

// Operation select codes
`define OP_SKIP_REG_BIT_ONE 5'h0_0
`define OP_SKIP_IO_BIT_LOW 5'h0_1
`define OP_SKIP_IO_BIT_HIGH 5'h0_2
`define OP_JUMP_FLAG_ONE 5'h0_3
`define OP_JUMP_FLAG_ZERO 5'h0_4
`define OP_JUMP_EQUAL 5'h0_5
`define OP_JUMP_UNEQUAL 5'h0_6
`define OP_JUMP_CARRY_ONE 5'h0_7
`define OP_JUMP_CARRY_ZERO 5'h0_8
`define OP_JUMP_UNSIGNED_AT_LEAST 5'h0_9
`define OP_JUMP_UNSIGNED_BELOW 5'h0_A
`define OP_JUMP_NEGATIVE 5'h0_B
`define OP_JUMP_POSITIVE 5'h0_C
`define OP_JUMP_SIGNED_AT_LEAST 5'h0_D
`define OP_JUMP_SIGNED_BELOW 5'h0_E
`define OP_JUMP_HALF_CARRY_ONE 5'h0_F
`define OP_JUMP_HALF_CARRY_ZERO 5'h1_0

// Flag positions in the status flags word
`define FLAG_CARRY 3'h0
`define FLAG_ZERO 3'h1
`define FLAG_NEGATIVE 3'h2
`define FLAG_OVERFLOW 3'h3
`define FLAG_SIGN 3'h4
`define FLAG_HALF_CARRY 3'h5

// Cycle costs
`define CYCLES_NOT_TAKEN 2'h1
`define CYCLES_BRANCH_TAKEN 2'h2
`define CYCLES_SKIP_ONE_WORD 2'h2
`define CYCLES_SKIP_TWO_WORD 2'h3

// Program counter advance for a skip or a plain step, in words
`define SKIP_ONE_WORD_STEP 2'h2
`define SKIP_TWO_WORD_STEP 2'h3
`define PC_STEP 2'h1

// Reset values
`define PC_RESET 16'h0000
`define FLAGS_RESET 8'h00

`endif

// ---- design/conditional_branch_skip_unit.v ----
`timescale 1ns/1ps
// Overview of operation
// - Skip next instruction when selected general register bit is one; PC plus 2 or 3.
// - I/O skip tests selected I/O bit; low variant skips on zero, high on one.
// - Generic flag jumps pick a flag by index; taken gives PC plus offset plus one.
// - Equal jumps when zero flag is one; unequal when it is zero.
// - Carry-one jumps when carry is one; carry-zero jumps when carry is zero.
// - Unsigned at-least jumps on carry zero; unsigned below jumps on carry one.
// - Negative jumps when negative flag is one; positive when it is zero.
// - Signed at-least jumps when negative xor overflow is zero.
// - Signed below jumps when negative xor overflow is one.
// - Half-carry pair jumps on half-carry flag set or cleared.
// - No skip or jump changes any status flag, taken or not.
`include "branch_skip_map.vh"

module conditional_branch_skip_unit #(
	parameter PC_WIDTH = 16,
	parameter OFFSET_WIDTH = 7
) (
	input wire sys_clk,
	input wire rst_n,
	input wire clk_en,
	input wire start,
	input wire [4:0] op_code,
	input wire [2:0] bit_sel,
	input wire [7:0] reg_value,
	input wire [7:0] io_value,
	input wire [OFFSET_WIDTH-1:0] offset,
	input wire next_is_two_word,
	input wire [PC_WIDTH-1:0] pc_in,
	input wire [7:0] status_flags_word,
	output wire busy,
	output reg done_reg,
	output reg taken_reg,
	output reg bad_op_reg,
	output reg [1:0] cycles_reg,
	output reg [PC_WIDTH-1:0] pc_out_reg,
	output reg [7:0] flags_out_reg
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

// Pick one bit of a byte by index
function pick_bit;
	input [7:0] word;
	input [2:0] idx;
	begin
		pick_bit = word[idx];
	end
endfunction

// Sign-extend the displacement to the program counter width
function [PC_WIDTH-1:0] extend_offset;
	input [OFFSET_WIDTH-1:0] disp;
	begin
		extend_offset = {{(PC_WIDTH-OFFSET_WIDTH){disp[OFFSET_WIDTH-1]}}, disp};
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// State machine encoding

localparam IDLE = 2'b00;
localparam RUN = 2'b01;

reg [1:0] state_reg;
reg [1:0] state_next;
reg [1:0] count_reg;
reg [1:0] count_next;
reg done_next;
reg taken_next;
reg bad_op_next;
reg [1:0] cycles_next;
reg [PC_WIDTH-1:0] pc_out_next;
reg [7:0] flags_out_next;

////////////////////////////////////////////////////////////////////////////////
// Condition evaluation

reg is_skip;
reg is_valid;
reg cond_met;
wire flag_carry;
wire flag_zero;
wire flag_negative;
wire flag_overflow;
wire flag_half;
wire signed_less;

assign flag_carry = pick_bit(status_flags_word, `FLAG_CARRY);
assign flag_zero = pick_bit(status_flags_word, `FLAG_ZERO);
assign flag_negative = pick_bit(status_flags_word, `FLAG_NEGATIVE);
assign flag_overflow = pick_bit(status_flags_word, `FLAG_OVERFLOW);
assign flag_half = pick_bit(status_flags_word, `FLAG_HALF_CARRY);
assign signed_less = flag_negative ^ flag_overflow;

always @* begin
	is_skip = 1'b0;
	is_valid = 1'b1;
	cond_met = 1'b0;
	case (op_code)
		`OP_SKIP_REG_BIT_ONE: begin
			is_skip = 1'b1;
			cond_met = pick_bit(reg_value, bit_sel);
		end
		`OP_SKIP_IO_BIT_LOW: begin
			is_skip = 1'b1;
			cond_met = ~pick_bit(io_value, bit_sel);
		end
		`OP_SKIP_IO_BIT_HIGH: begin
			is_skip = 1'b1;
			cond_met = pick_bit(io_value, bit_sel);
		end
		`OP_JUMP_FLAG_ONE: begin
			cond_met = pick_bit(status_flags_word, bit_sel);
		end
		`OP_JUMP_FLAG_ZERO: begin
			cond_met = ~pick_bit(status_flags_word, bit_sel);
		end
		`OP_JUMP_EQUAL: begin
			cond_met = flag_zero;
		end
		`OP_JUMP_UNEQUAL: begin
			cond_met = ~flag_zero;
		end
		`OP_JUMP_CARRY_ONE: begin
			cond_met = flag_carry;
		end
		`OP_JUMP_CARRY_ZERO: begin
			cond_met = ~flag_carry;
		end
		`OP_JUMP_UNSIGNED_AT_LEAST: begin
			cond_met = ~flag_carry;
		end
		`OP_JUMP_UNSIGNED_BELOW: begin
			cond_met = flag_carry;
		end
		`OP_JUMP_NEGATIVE: begin
			cond_met = flag_negative;
		end
		`OP_JUMP_POSITIVE: begin
			cond_met = ~flag_negative;
		end
		`OP_JUMP_SIGNED_AT_LEAST: begin
			cond_met = ~signed_less;
		end
		`OP_JUMP_SIGNED_BELOW: begin
			cond_met = signed_less;
		end
		`OP_JUMP_HALF_CARRY_ONE: begin
			cond_met = flag_half;
		end
		`OP_JUMP_HALF_CARRY_ZERO: begin
			cond_met = ~flag_half;
		end
		default: begin
			is_valid = 1'b0;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Target and cost

reg [PC_WIDTH-1:0] target_pc;
reg [1:0] cost;

always @* begin
	target_pc = pc_in + {{(PC_WIDTH-2){1'b0}}, `PC_STEP};
	cost = `CYCLES_NOT_TAKEN;
	if (is_valid && cond_met) begin
		if (is_skip) begin
			if (next_is_two_word) begin
				target_pc = pc_in + {{(PC_WIDTH-2){1'b0}}, `SKIP_TWO_WORD_STEP};
				cost = `CYCLES_SKIP_TWO_WORD;
			end else begin
				target_pc = pc_in + {{(PC_WIDTH-2){1'b0}}, `SKIP_ONE_WORD_STEP};
				cost = `CYCLES_SKIP_ONE_WORD;
			end
		end else begin
			target_pc = pc_in + extend_offset(offset) + {{(PC_WIDTH-2){1'b0}}, `PC_STEP};
			cost = `CYCLES_BRANCH_TAKEN;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sequencing

assign busy = (state_reg == RUN);

always @* begin
	state_next = state_reg;
	count_next = count_reg;
	done_next = 1'b0;
	taken_next = taken_reg;
	bad_op_next = bad_op_reg;
	cycles_next = cycles_reg;
	pc_out_next = pc_out_reg;
	flags_out_next = flags_out_reg;
	case (state_reg)
		IDLE: begin
			if (start) begin
				state_next = RUN;
				count_next = cost - 2'h1;
				taken_next = is_valid & cond_met;
				bad_op_next = ~is_valid;
				cycles_next = cost;
				pc_out_next = target_pc;
				flags_out_next = status_flags_word;
			end
		end
		RUN: begin
			if (count_reg == 2'h0) begin
				state_next = IDLE;
				done_next = 1'b1;
			end else begin
				count_next = count_reg - 2'h1;
			end
		end
		default: begin
			state_next = IDLE;
		end
	endcase
end

always @(posedge sys_clk or negedge rst_n) begin
	if (!rst_n) begin
		state_reg <= IDLE;
		count_reg <= 2'h0;
		done_reg <= 1'b0;
		taken_reg <= 1'b0;
		bad_op_reg <= 1'b0;
		cycles_reg <= 2'h0;
		pc_out_reg <= `PC_RESET;
		flags_out_reg <= `FLAGS_RESET;
	end else if (clk_en) begin
		state_reg <= state_next;
		count_reg <= count_next;
		done_reg <= done_next;
		taken_reg <= taken_next;
		bad_op_reg <= bad_op_next;
		cycles_reg <= cycles_next;
		pc_out_reg <= pc_out_next;
		flags_out_reg <= flags_out_next;
	end
end

endmodule

// ---- testbench/conditional_branch_skip_unit_assertions.sv ----
`timescale 1ns/1ps
module branch_skip_checker (
	input wire sys_clk,
	input wire rst_n,
	input wire clk_en,
	input wire start,
	input wire [4:0] op_code,
	input wire [15:0] pc_in,
	input wire [7:0] status_flags_word,
	input wire busy,
	input wire done_reg,
	input wire taken_reg,
	input wire bad_op_reg,
	input wire [1:0] cycles_reg,
	input wire [15:0] pc_out_reg,
	input wire [7:0] flags_out_reg
);
	wire tk = start && !busy && clk_en;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_fl; tk |=> flags_out_reg == $past(status_flags_word); endproperty
	a_fl: assert property (p_fl) else $error("flags changed");
	property p_nt; tk ##1 !taken_reg |-> pc_out_reg == $past(pc_in) + 16'h0001; endproperty
	a_nt: assert property (p_nt) else $error("not taken pc");
	property p_sk;
		tk ##1 cycles_reg == 2'h3 |-> taken_reg && pc_out_reg == $past(pc_in) + 16'h0003;
	endproperty
	a_sk: assert property (p_sk) else $error("two word skip pc");
	property p_eq; tk && op_code == 5'h05 |=> taken_reg == $past(status_flags_word[1]); endproperty
	a_eq: assert property (p_eq) else $error("equal jump");
	property p_bd; tk ##1 bad_op_reg |-> !taken_reg && cycles_reg == 2'h1; endproperty
	a_bd: assert property (p_bd) else $error("bad op");
	property p_l1;
		disable iff (!rst_n || !clk_en) tk ##1 cycles_reg == 2'h1 |=> done_reg;
	endproperty
	a_l1: assert property (p_l1) else $error("one cycle");
	property p_l2;
		disable iff (!rst_n || !clk_en) tk ##1 cycles_reg == 2'h2 |=> !done_reg ##1 done_reg;
	endproperty
	a_l2: assert property (p_l2) else $error("two cycles");
	property p_l3;
		disable iff (!rst_n || !clk_en) tk ##1 cycles_reg == 2'h3 |=> !done_reg [*2] ##1 done_reg;
	endproperty
	a_l3: assert property (p_l3) else $error("three cycles");
endmodule
bind conditional_branch_skip_unit branch_skip_checker chk_i (.*);

// ---- testbench/conditional_branch_skip_unit_tb.sv ----
`timescale 1ns/1ps
module conditional_branch_skip_unit_tb;
	reg sys_clk = 0, rst_n = 0, start = 0, two = 0, c, bd, en = 1;
	integer t;
	reg [4:0] op = 0;
	reg [2:0] bs = 0;
	reg [7:0] rv = 0, iv = 0, sf = 0, es;
	reg [6:0] k = 0;
	reg [15:0] pc = 0, ep;
	reg [16:0] v;
	reg [1:0] ec;
	reg [31:0] lf = 32'h05a3_ef82;
	wire busy, done, tk, bad;
	wire [1:0] cyc;
	wire [15:0] po;
	wire [7:0] fo;
	integer n_mismatch = 0, checks = 0, i, w;
	conditional_branch_skip_unit DUT (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(en),
		.start(start), .op_code(op), .bit_sel(bs), .reg_value(rv), .io_value(iv), .offset(k),
		.next_is_two_word(two), .pc_in(pc), .status_flags_word(sf), .busy(busy),
		.done_reg(done), .taken_reg(tk), .bad_op_reg(bad), .cycles_reg(cyc),
		.pc_out_reg(po), .flags_out_reg(fo));
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task chk(input [8*6:1] nm, input [15:0] e, input [15:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task end_of_test;
		begin
			$display("checks %0d n_mismatch %0d", checks, n_mismatch);
			if (n_mismatch == 0 && checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task run;
		begin
			v = {!sf[5], sf[5], sf[2] ^ sf[3], !(sf[2] ^ sf[3]), !sf[2], sf[2], sf[0], !sf[0],
				!sf[0], sf[0], !sf[1], sf[1], !sf[bs], sf[bs], iv[bs], !iv[bs], rv[bs]};
			bd = op > 5'h10;
			c = v[op] & !bd;
			ec = !c ? 2'h1 : (op < 5'h03 && two) ? 2'h3 : 2'h2;
			ep = !c ? pc + 16'h0001 : op < 5'h03 ? pc + {14'h0000, ec}
				: pc + {{9{k[6]}}, k} + 16'h0001;
			es = sf;
			start = 1;
			@(posedge sys_clk);
			#1 start = 0;
			chk("busy", 16'h0001, {15'h0000, busy});
			lf = nx(lf);
			{sf, pc} = lf[23:0];
			w = 0;
			t = 0;
			while (done !== 1'b1 && t < 20) begin
				@(posedge sys_clk);
				#1 w = w + en;
				t = t + 1;
				en = (done === 1'b1) ? 1'b1 : (!i[0] | !en);
			end
			chk("done", 16'h0001, {15'h0000, done});
			chk("pc", ep, po);
			chk("taken", {15'h0000, c}, {15'h0000, tk});
			chk("bad", {15'h0000, bd}, {15'h0000, bad});
			chk("cycles", {14'h0000, ec}, {14'h0000, cyc});
			chk("wait", {14'h0000, ec}, w[15:0]);
			chk("flags", {8'h00, es}, {8'h00, fo});
			if (t > 19)
				end_of_test;
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		#1 rst_n = 1;
		for (i = 0; i < 400; i = i + 1) begin
			lf = nx(lf);
			{rv, iv, sf, k} = lf[30:0];
			lf = nx(lf);
			{pc, bs, two} = lf[19:0];
			op = (i < 17) ? i[4:0] : lf[28:24] % 5'h12;
			if (i == 0) begin
				rv = 8'hff;
				two = 1;
			end
			if (i == 5) begin
				sf = 8'h02;
				k = 7'h40;
				pc = 16'h0000;
			end
			run;
		end
		end_of_test;
	end
endmodule
